//--- logic/dpbs_sram.sv
// Function
// - data splits into four 9-bit lanes, each gated by its enable.
// - selected write stores only lanes whose enables are low.
// - selected read with output enable drives only enabled lanes.
// - any combination of lane enables is a legal access.
// - output enable high floats all data lines without a clock.
// - each port reaches any bank the other port is not using.
// - same-bank clash with a write blocks both ports' writes; neither word changes.
// - same-bank clash of two reads returns invalid data.
// - repeat reloads the counter with the last strobe-loaded address.
// - address strobe low loads the external address, ignoring selects.
// - counter enable low advances the counter by one, ignoring selects.
// - counter spans bank and word, wrapping from last bank to zero.
// - pipelined mode delays read data one cycle over flow-through.
`timescale 1ns/1ps
`default_nettype none
`include "dpbs_map.svh"
module dpbs_sram (
  input  wire logic                clock,
  input  wire logic                reset,
  input  wire dpbs_pkg::dpbs_req_s left_req,
  input  wire logic                left_output_enable_n,
  input  wire dpbs_pkg::dpbs_req_s right_req,
  input  wire logic                right_output_enable_n,
  output var  dpbs_pkg::dpbs_data_t left_data_out,
  output var  dpbs_pkg::dpbs_data_t left_data_oe,
  output var  logic                left_bank_conflict,
  output var  dpbs_pkg::dpbs_data_t right_data_out,
  output var  dpbs_pkg::dpbs_data_t right_data_oe,
  output var  logic                right_bank_conflict
);
  import dpbs_pkg::*;

  dpbs_core_state_s state_reg;
  dpbs_core_state_s state_next;
  dpbs_access_s     acc [2];
  dpbs_req_s        req [2];
  dpbs_data_t       read_word [2];
  logic             conflict;
  // flip-flop array; too large for the state struct
  dpbs_data_t       mem [`DPBS_WORDS];

  assign req[0] = left_req;
  assign req[1] = right_req;

  //////////////////////////////////////////////////////////////////////////
  // separate port paths
  dpbs_port u_left (
    .clock  (clock),
    .reset  (reset),
    .req    (left_req),
    .access (acc[0])
  );

  dpbs_port u_right (
    .clock  (clock),
    .reset  (reset),
    .req    (right_req),
    .access (acc[1])
  );

  //////////////////////////////////////////////////////////////////////////
  // clash only on equal banks
  assign conflict = acc[0].select && acc[1].select
                    && dpbs_bank(acc[0].addr) == dpbs_bank(acc[1].addr);

  // read and output staging for both ports
  always_comb begin
    state_next = state_reg;
    for (int p = 0; p < 2; p++) begin
      read_word[p] = conflict ? `DPBS_POISON : mem[acc[p].addr];
      state_next.stage_data[p]  = read_word[p];
      state_next.stage_lanes[p] = acc[p].read ? acc[p].lanes : '0;
      if (req[p].pipeline_select) begin
        state_next.out_data[p]  = state_reg.stage_data[p];
        state_next.out_lanes[p] = state_reg.stage_lanes[p];
      end else begin
        state_next.out_data[p]  = read_word[p];
        state_next.out_lanes[p] = state_next.stage_lanes[p];
      end
      state_next.conflict[p] = conflict;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // array write; a read of the same word sees the old value
  always_ff @(posedge clock) begin
    for (int p = 0; p < 2; p++) begin
      for (int l = 0; l < `DPBS_LANES; l++) begin
        if (!reset && acc[p].write && !conflict && acc[p].lanes[l]) begin
          mem[acc[p].addr][l*`DPBS_LANE_W +: `DPBS_LANE_W] <=
            req[p].data_in[l*`DPBS_LANE_W +: `DPBS_LANE_W];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs: data and conflict from flops
  assign left_data_out       = state_reg.out_data[0];
  assign right_data_out      = state_reg.out_data[1];
  assign left_bank_conflict  = state_reg.conflict[0];
  assign right_bank_conflict = state_reg.conflict[1];
  // enable gate is asynchronous
  // the one path that skips a flop, since the pin must act without a clock
  assign left_data_oe  = dpbs_lane_bits(state_reg.out_lanes[0])
                         & {`DPBS_DATA_W{~left_output_enable_n}};
  assign right_data_oe = dpbs_lane_bits(state_reg.out_lanes[1])
                         & {`DPBS_DATA_W{~right_output_enable_n}};

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_oe_float;
    left_output_enable_n |-> left_data_oe == '0;
  endproperty
  a_oe_float: assert property (p_oe_float)
    else $error("data driven while output enable high");

  property p_deselect;
    !acc[0].select && !left_req.pipeline_select
      |=> state_reg.out_lanes[0] == '0 ##0 left_data_oe == '0;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("deselected port drives data");

  property p_read_lanes;
    acc[0].read && !left_req.pipeline_select && !left_output_enable_n
      |=> left_data_oe == dpbs_lane_bits($past(acc[0].lanes))
          || left_output_enable_n;
  endproperty
  a_read_lanes: assert property (p_read_lanes)
    else $error("read lanes do not match byte enables");

  property p_pipe_delay;
    acc[1].read && right_req.pipeline_select
      ##1 right_req.pipeline_select
      |=> state_reg.out_lanes[1] == $past(acc[1].lanes, 2)
          && right_data_out == $past(read_word[1], 2);
  endproperty
  a_pipe_delay: assert property (p_pipe_delay)
    else $error("pipelined read not two edges late");

  property p_flow_data;
    acc[1].read && !right_req.pipeline_select && !conflict
      |=> right_data_out == mem[$past(acc[1].addr)];
  endproperty
  a_flow_data: assert property (p_flow_data)
    else $error("flow-through read returned wrong word");

  property p_write_lane0;
    acc[0].write && !conflict && acc[0].lanes[0]
      |=> mem[$past(acc[0].addr)][8:0] == $past(left_req.data_in[8:0]);
  endproperty
  a_write_lane0: assert property (p_write_lane0)
    else $error("enabled lane 0 not written");

  property p_clash_read;
    conflict && acc[0].read && !left_req.pipeline_select
      |=> left_data_out == `DPBS_POISON && left_bank_conflict;
  endproperty
  a_clash_read: assert property (p_clash_read)
    else $error("same-bank read did not return poison");

  property p_clash_write;
    conflict && acc[0].write
      ##0 acc[0].addr != acc[1].addr
      |=> right_bank_conflict && left_bank_conflict;
  endproperty
  a_clash_write: assert property (p_clash_write)
    else $error("write clash not flagged on both ports");

  // right port: same float rules as the left, both pins are live
  property p_oe_float_right;
    right_output_enable_n |-> right_data_oe == '0;
  endproperty
  a_oe_float_right: assert property (p_oe_float_right)
    else $error("right data driven while output enable high");

  property p_deselect_right;
    !acc[1].select && !right_req.pipeline_select
      |=> state_reg.out_lanes[1] == '0 ##0 right_data_oe == '0;
  endproperty
  a_deselect_right: assert property (p_deselect_right)
    else $error("deselected right port drives data");

  property p_read_lanes_right;
    acc[1].read && !right_req.pipeline_select && !right_output_enable_n
      |=> right_data_oe == dpbs_lane_bits($past(acc[1].lanes))
          || right_output_enable_n;
  endproperty
  a_read_lanes_right: assert property (p_read_lanes_right)
    else $error("right read lanes do not match byte enables");

  // a write never turns the data drivers on
  property p_write_quiet;
    acc[0].write && !left_req.pipeline_select |=> left_data_oe == '0;
  endproperty
  a_write_quiet: assert property (p_write_quiet)
    else $error("write cycle drives left data");

  // flag only after a real same-bank clash
  property p_no_clash_flag;
    !conflict |=> !left_bank_conflict && !right_bank_conflict;
  endproperty
  a_no_clash_flag: assert property (p_no_clash_flag)
    else $error("conflict flagged without a same-bank clash");

  c_left_read:   cover property (acc[0].read && !conflict);
  c_right_write: cover property (acc[1].write && !conflict);
  c_clash:       cover property (conflict);
  c_partial:     cover property (acc[0].write && acc[0].lanes == 4'h5);
endmodule // dpbs_sram
`default_nettype wire

//--- logic/dpbs_map.svh
`ifndef DPBS_MAP_SVH
`define DPBS_MAP_SVH
// data path shape
`define DPBS_LANES       4
`define DPBS_LANE_W      9
`define DPBS_DATA_W      36
// address shape: bank above word
`define DPBS_BANK_W      6
`define DPBS_WORD_W      10
`define DPBS_ADDR_W      16
`define DPBS_WORDS       65536
// field positions inside the counter address
`define DPBS_BANK_LSB    10
`define DPBS_BANK_MSB    15
// reset values and counter step
`define DPBS_COUNT_RESET 16'h0000
`define DPBS_COUNT_STEP  16'h0001
// read value returned when both ports hit one bank
`define DPBS_POISON      36'hFFFFFFFFF
`endif

//--- logic/dpbs_pkg.sv
`default_nettype none
package dpbs_pkg;
  `include "dpbs_map.svh"

  typedef logic [`DPBS_ADDR_W-1:0] dpbs_addr_t;
  typedef logic [`DPBS_DATA_W-1:0] dpbs_data_t;
  typedef logic [`DPBS_LANES-1:0]  dpbs_lanes_t;

  // one port's pin-level request, sampled at the rising edge
  typedef struct packed {
    logic                    chip_select_low_active;
    logic                    chip_select_high_active;
    logic                    read_not_write;
    dpbs_lanes_t             byte_lane_enable_n;
    logic [`DPBS_BANK_W-1:0] bank_select;
    logic [`DPBS_WORD_W-1:0] word_address;
    logic                    address_strobe_n;
    logic                    counter_enable_n;
    logic                    counter_repeat_n;
    logic                    pipeline_select;
    dpbs_data_t              data_in;
  } dpbs_req_s;

  // decoded access of one port for this edge
  typedef struct packed {
    logic        select;
    logic        write;
    logic        read;
    dpbs_lanes_t lanes;
    dpbs_addr_t  addr;
  } dpbs_access_s;

  // address counter state of one port
  typedef struct packed {
    dpbs_addr_t count;
    dpbs_addr_t repeat_addr;
  } dpbs_port_state_s;

  // output staging of both ports
  typedef struct packed {
    logic [1:0][`DPBS_DATA_W-1:0] stage_data;
    logic [1:0][`DPBS_DATA_W-1:0] out_data;
    logic [1:0][`DPBS_LANES-1:0]  stage_lanes;
    logic [1:0][`DPBS_LANES-1:0]  out_lanes;
    logic [1:0]                   conflict;
  } dpbs_core_state_s;

  // widen a lane mask to one bit per data line
  function automatic dpbs_data_t dpbs_lane_bits(input dpbs_lanes_t lanes);
    dpbs_data_t bits;
    bits = '0;
    for (int l = 0; l < `DPBS_LANES; l++) begin
      bits[l*`DPBS_LANE_W +: `DPBS_LANE_W] = {`DPBS_LANE_W{lanes[l]}};
    end
    return bits;
  endfunction

  // bank field of a counter address
  function automatic logic [`DPBS_BANK_W-1:0] dpbs_bank(input dpbs_addr_t a);
    return a[`DPBS_BANK_MSB:`DPBS_BANK_LSB];
  endfunction
endpackage
`default_nettype wire

//--- logic/dpbs_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "dpbs_map.svh"
module dpbs_port (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire dpbs_pkg::dpbs_req_s req,
  output var  dpbs_pkg::dpbs_access_s access
);
  import dpbs_pkg::*;

  dpbs_port_state_s state_reg;
  dpbs_port_state_s state_next;
  logic             selected;

  //////////////////////////////////////////////////////////////////////////
  // address source and access decode
  always_comb begin
    state_next = state_reg;
    access     = '0;
    if (!req.counter_repeat_n) begin
      access.addr = state_reg.repeat_addr;
    end else if (!req.address_strobe_n) begin
      access.addr            = {req.bank_select, req.word_address};
      state_next.repeat_addr = {req.bank_select, req.word_address};
    end else if (!req.counter_enable_n) begin
      access.addr = state_reg.count + `DPBS_COUNT_STEP;
    end else begin
      access.addr = state_reg.count;
    end
    state_next.count = access.addr;
    selected      = !req.chip_select_low_active && req.chip_select_high_active;
    access.select = selected;
    access.lanes  = selected ? ~req.byte_lane_enable_n : '0;
    access.write  = selected && !req.read_not_write && (|access.lanes);
    access.read   = selected && req.read_not_write && (|access.lanes);
  end

  // counter register; power-up value is arbitrary, zero is chosen
  always_ff @(posedge clock) begin
    if (reset) begin
      state_reg <= {`DPBS_COUNT_RESET, `DPBS_COUNT_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  property p_ads_load;
    req.counter_repeat_n && !req.address_strobe_n
      |=> state_reg.repeat_addr == $past({req.bank_select, req.word_address})
          && state_reg.count == state_reg.repeat_addr;
  endproperty
  a_ads_load: assert property (p_ads_load)
    else $error("address strobe load not captured");

  property p_count_step;
    req.counter_repeat_n && req.address_strobe_n && !req.counter_enable_n
      && state_reg.count != 16'hFFFF
      |=> state_reg.count == $past(state_reg.count) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance by one");

  property p_count_wrap;
    req.counter_repeat_n && req.address_strobe_n && !req.counter_enable_n
      && state_reg.count == 16'hFFFF |=> state_reg.count == 16'h0000;
  endproperty
  a_count_wrap: assert property (p_count_wrap)
    else $error("counter did not wrap to bank zero");

  property p_repeat;
    !req.counter_repeat_n |-> access.addr == state_reg.repeat_addr
      ##1 state_reg.count == $past(state_reg.repeat_addr);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat did not reload last strobe address");

  c_bank_carry: cover property (req.counter_repeat_n && req.address_strobe_n
    && !req.counter_enable_n && state_reg.count[9:0] == 10'h3FF);
endmodule // dpbs_port
`default_nettype wire

//--- bench/dpbs_master.sv
`timescale 1ns/1ps
`default_nettype none
module dpbs_master (
  input  wire logic                clock,
  input  wire dpbs_pkg::dpbs_req_s left_cmd,
  input  wire dpbs_pkg::dpbs_req_s right_cmd,
  input  wire logic                allow_clash,
  output var  dpbs_pkg::dpbs_req_s left_req,
  output var  dpbs_pkg::dpbs_req_s right_req
);
  import dpbs_pkg::*;
  logic [3:0] wig_reg = 4'h0;

  ////////////////////////////////////////////////////////////
  // free pattern: a read never leaves old write data on the bus
  always_ff @(posedge clock) begin
    wig_reg <= wig_reg + 4'h1;
  end

  // pass commands on, keeping the two ports off one bank
  always_comb begin
    left_req  = left_cmd;
    right_req = right_cmd;
    if (left_cmd.read_not_write) begin
      left_req.data_in = {9{wig_reg}};
    end
    if (right_cmd.read_not_write) begin
      right_req.data_in = {9{~wig_reg}};
    end
    if (!allow_clash && left_cmd.bank_select == right_cmd.bank_select) begin
      right_req.chip_select_high_active = 1'b0;
    end
  end
endmodule // dpbs_master
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dpbs_pkg::*;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] oe_n  = 2'b00;
  logic       clash = 1'b0;
  logic       pl    = 1'b0;
  logic       lf, rf;
  dpbs_req_s  lc, rc, lq, rq, q;
  dpbs_data_t ld, lo, rd, ro;
  dpbs_addr_t al, ar;
  int         err_total  = 0;
  int         num_checks = 0;
  int         cyc        = 0;
  dpbs_data_t mem [0:65535];

  always #50 clock = ~clock;

  dpbs_master u_far (.clock(clock), .left_cmd(lc), .right_cmd(rc),
    .allow_clash(clash), .left_req(lq), .right_req(rq));
  dpbs_sram u_dut (.clock(clock), .reset(reset), .left_req(lq),
    .left_output_enable_n(oe_n[0]), .right_req(rq),
    .right_output_enable_n(oe_n[1]), .left_data_out(ld),
    .left_data_oe(lo), .left_bank_conflict(lf), .right_data_out(rd),
    .right_data_oe(ro), .right_bank_conflict(rf));

  ////////////////////////////////////////////////////////////
  // expectation helpers
  function automatic dpbs_data_t msk(input dpbs_lanes_t be_n);
    msk = '0;
    for (int l = 0; l < 4; l++) begin
      if (!be_n[l]) msk[l*9 +: 9] = 9'h1FF;
    end
  endfunction

  function automatic dpbs_req_s mk(input logic rnw, input dpbs_lanes_t be_n,
                                   input dpbs_addr_t a, input dpbs_data_t d);
    mk = '{1'b0, 1'b1, rnw, be_n, a[15:10], a[9:0], 1'b0, 1'b1, 1'b1, pl, d};
  endfunction

  // deselected, counter held: the quiet state between accesses
  function automatic dpbs_req_s idle();
    idle = mk(1'b1, 4'hF, 16'h0000, '0);
    idle.chip_select_low_active = 1'b1;
    idle.address_strobe_n = 1'b1;
  endfunction

  function automatic logic sel(input dpbs_req_s r);
    sel = !r.chip_select_low_active && r.chip_select_high_active;
  endfunction

  function automatic dpbs_data_t rnd();
    rnd = {4'($urandom), $urandom};
  endfunction

  task automatic chk(input dpbs_data_t g, input dpbs_data_t e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic chk_bit(input logic g, input logic e);
    chk({35'h0, g}, {35'h0, e});
  endtask

  // one access per port, then a quiet edge so nothing is taken twice
  task automatic go(input dpbs_req_s l, input dpbs_req_s r);
    @(posedge clock);
    lc <= l;
    rc <= r;
    @(posedge clock);
    lc <= idle();
    rc <= idle();
    #1;
    if (pl) begin
      chk(lo, '0);
      @(posedge clock);
      #1;
    end
  endtask

  task automatic exam(input dpbs_req_s r, input dpbs_addr_t a,
                      input dpbs_data_t g, input dpbs_data_t o);
    dpbs_data_t m;
    m = (sel(r) && r.read_not_write) ? msk(r.byte_lane_enable_n) : '0;
    chk(g & m, mem[a] & m);
    chk(o, m);
  endtask

  // reference memory follows only selected writes, lane by lane
  task automatic upd(input dpbs_req_s r);
    dpbs_addr_t a;
    dpbs_data_t m;
    a = {r.bank_select, r.word_address};
    m = msk(r.byte_lane_enable_n);
    if (sel(r) && !r.read_not_write) mem[a] = mem[a] & ~m | r.data_in & m;
  endtask

  task automatic op(input dpbs_req_s l, input dpbs_req_s r);
    go(l, r);
    exam(l, {l.bank_select, l.word_address}, ld, lo);
    exam(r, {r.bank_select, r.word_address}, rd, ro);
    chk_bit(lf | rf, 1'b0);
    upd(l);
    upd(r);
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    lc = idle();
    rc = idle();
    void'($urandom(32'hF40419BB));
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    // both ports on distinct banks, every lane mix, random output mode
    for (int i = 0; i < 32; i++) begin
      al = 16'($urandom);
      ar = 16'($urandom);
      if (ar[15:10] == al[15:10]) ar[15:10] = ~al[15:10];
      op(mk(1'b0, 4'h0, al, rnd()), mk(1'b0, 4'h0, ar, rnd()));
      op(mk(1'b0, i[3:0], al, rnd()), mk(1'b0, ~i[3:0], ar, rnd()));
      pl = 1'($urandom);
      go(idle(), idle());
      op(mk(1'b1, 4'($urandom), al, '0), mk(1'b1, i[3:0], ar, '0));
      pl = 1'b0;
      go(idle(), idle());
    end
    done("lanes");
    // either select inactive blocks the write
    q = mk(1'b0, 4'h0, 16'h0ABC, rnd());
    q.chip_select_low_active = 1'b1;
    op(q, idle());
    q.chip_select_low_active = 1'b0;
    q.chip_select_high_active = 1'b0;
    op(q, idle());
    op(mk(1'b1, 4'h0, 16'h0ABC, '0), idle());
    // hold a read two edges; a registered enable would lag by one edge
    @(posedge clock);
    lc <= mk(1'b1, 4'h0, 16'h0ABC, '0);
    @(posedge clock);
    oe_n <= 2'b11;
    #1 chk(lo, '0);
    @(posedge clock);
    oe_n <= 2'b00;
    lc   <= idle();
    #1 chk(lo, 36'hFFFFFFFFF);
    done("select");
    // strobe load while deselected, advance across the top, repeat
    op(mk(1'b0, 4'h0, 16'hFFFF, rnd()), idle());
    op(mk(1'b0, 4'h0, 16'h0000, rnd()), idle());
    q = mk(1'b1, 4'h0, 16'hFFFF, '0);
    q.chip_select_high_active = 1'b0;
    go(q, idle());
    exam(q, 16'hFFFF, ld, lo);
    q = mk(1'b1, 4'h0, 16'h5555, '0);
    q.address_strobe_n = 1'b1;
    q.counter_enable_n = 1'b0;
    go(q, idle());
    exam(q, 16'h0000, ld, lo);
    q.counter_enable_n = 1'b1;
    q.counter_repeat_n = 1'b0;
    go(q, idle());
    exam(q, 16'hFFFF, ld, lo);
    done("counter");
    // both ports on bank 63 at once
    clash = 1'b1;
    go(mk(1'b1, 4'h0, 16'hFFFF, '0), mk(1'b1, 4'h0, 16'hFC00, '0));
    chk_bit(lf & rf, 1'b1);
    chk(ld, 36'hFFFFFFFFF);
    go(mk(1'b0, 4'h0, 16'hFFFF, rnd()), mk(1'b0, 4'h0, 16'hFC01, rnd()));
    chk_bit(rf, 1'b1);
    clash = 1'b0;
    op(mk(1'b1, 4'h0, 16'hFFFF, '0), idle());
    done("clash");
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
